// File: verilog/sppl_builder.sv
`timescale 1ns/10ps
`default_nettype none
`include "sppl_defines.svh"

module sppl_builder
  import sppl_pkg::*;
#(
  parameter int MAX_PHYS = 4
) (
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  // wishbone slave
  input  wire logic                    i_wb_cyc,
  input  wire logic                    i_wb_stb,
  input  wire logic                    i_wb_we,
  input  wire logic [3:0]              i_wb_adr,
  input  wire logic [3:0]              i_wb_sel,
  input  wire logic [31:0]             i_wb_dat,
  output logic      [31:0]             o_wb_dat,
  output logic                         o_wb_ack,
  // per-phy facts, phy n in slice n
  input  wire logic [MAX_PHYS*8-1:0]   i_phy_id,
  input  wire logic [MAX_PHYS*3-1:0]   i_att_dev_type,
  input  wire logic [MAX_PHYS*4-1:0]   i_link_rate,
  input  wire logic [MAX_PHYS*3-1:0]   i_att_init,
  input  wire logic [MAX_PHYS*3-1:0]   i_att_tgt,
  input  wire logic [MAX_PHYS*64-1:0]  i_sas_addr,
  input  wire logic [MAX_PHYS*64-1:0]  i_att_addr,
  input  wire logic [MAX_PHYS*8-1:0]   i_att_phy_id,
  input  wire logic [MAX_PHYS*128-1:0] i_err_cnt,
  // page byte stream
  input  wire logic                    i_byte_ready,
  output logic      [7:0]              o_byte_data,
  output logic                         o_byte_valid,
  output logic                         o_byte_last
);

  // parameter length is one byte: 5 + 48*n must fit
  if (MAX_PHYS < 1 || MAX_PHYS > 5) begin : g_bad_phys
    $error("sppl_builder: MAX_PHYS must be 1 to 5");
  end

  ////////////////////////////////////////////////////////////////////
  // registers and state
  sppl_state_e  state_r;
  logic [15:0]  port_id_r;
  logic [7:0]   count_cfg_r;
  logic [7:0]   count_r;
  logic         err_r;
  logic [3:0]   hdr_idx_r;
  logic [5:0]   dbyte_r;
  logic [7:0]   phy_r;
  logic [15:0]  gen_pos_r;
  logic [15:0]  out_pos_r;
  logic [7:0]   gen_byte;
  logic         gen_last;
  logic         load;
  logic         wb_req;
  logic         start_req;
  logic [15:0]  page_len;
  logic [7:0]   param_len;
  int           p;
  logic         busy;
  // slot of the byte now on the pins; lets the checks see descriptor layout
  logic [5:0]   out_dbyte_r;
  logic         out_desc_r;

  // request decode; outside idle, load fills the output slot whenever it is free or being emptied
  assign wb_req    = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign start_req = wb_req && i_wb_we && i_wb_sel[0] &&
                     i_wb_adr == `SPPL_ADR_CTRL && i_wb_dat[`SPPL_CTRL_START];
  assign load      = state_r != SPPL_IDLE && (!o_byte_valid || i_byte_ready);
  assign p         = int'(phy_r);
  // busy until the last byte is taken, so a new page never overwrites a pending one
  assign busy      = state_r != SPPL_IDLE || o_byte_valid;

  // lengths follow the count latched at start, not the live register
  assign page_len  = `SPPL_PARAM_HDR + 16'(`SPPL_DESC_BYTES * count_r);
  assign param_len = 8'(page_len - `SPPL_PLEN_ADJ);

  ////////////////////////////////////////////////////////////////////
  // wishbone: one-cycle registered ack, unmapped reads give zero
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      // a request is not taken in the cycle its ack is high, so a held stb gets an ack every other cycle
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          `SPPL_ADR_PORT:   o_wb_dat <= {16'h0, port_id_r};
          `SPPL_ADR_COUNT:  o_wb_dat <= {24'h0, count_cfg_r};
          `SPPL_ADR_STATUS: o_wb_dat <= {30'h0, err_r, busy};
          default:          o_wb_dat <= 32'h0;
        endcase
      end
    end
  end

  // configuration writes, byte lanes honoured
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      port_id_r   <= 16'h0;
      count_cfg_r <= 8'h0;
    end else if (wb_req && i_wb_we) begin
      if (i_wb_adr == `SPPL_ADR_PORT) begin
        if (i_wb_sel[0]) port_id_r[7:0]  <= i_wb_dat[7:0];
        if (i_wb_sel[1]) port_id_r[15:8] <= i_wb_dat[15:8];
      end
      if (i_wb_adr == `SPPL_ADR_COUNT && i_wb_sel[0]) begin
        count_cfg_r <= i_wb_dat[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer; a start while busy is ignored so a page is never torn
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_r   <= SPPL_IDLE;
      count_r   <= 8'h0;
      err_r     <= 1'b0;
      hdr_idx_r <= 4'h0;
      dbyte_r   <= 6'h0;
      phy_r     <= 8'h0;
      gen_pos_r <= 16'h0;
    end else begin
      case (state_r)
        SPPL_IDLE: begin
          // the pending last byte of the previous page must drain first
          if (start_req && !busy) begin
            // a count above the phys wired in is refused
            err_r <= count_cfg_r > 8'(MAX_PHYS);
            if (count_cfg_r <= 8'(MAX_PHYS)) begin
              count_r   <= count_cfg_r;
              state_r   <= SPPL_HDR;
              hdr_idx_r <= 4'h0;
              dbyte_r   <= 6'h0;
              phy_r     <= 8'h0;
              gen_pos_r <= 16'h0;
            end
          end
        end
        // the count byte closes the header; an empty port ends the page there
        SPPL_HDR: begin
          if (load) begin
            gen_pos_r <= gen_pos_r + 16'h1;
            hdr_idx_r <= hdr_idx_r + 4'h1;
            if (hdr_idx_r == `SPPL_HDR_LAST) begin
              state_r <= (count_r == 8'h0) ? SPPL_IDLE : SPPL_DESC;
            end
          end
        end
        // descriptor counter wraps at 48 and moves on to the next phy's slices
        SPPL_DESC: begin
          if (load) begin
            gen_pos_r <= gen_pos_r + 16'h1;
            dbyte_r   <= dbyte_r + 6'h1;
            if (dbyte_r == `SPPL_D_LAST) begin
              dbyte_r <= 6'h0;
              phy_r   <= phy_r + 8'h1;
              if (phy_r == count_r - 8'h1) begin
                state_r <= SPPL_IDLE;
              end
            end
          end
        end
        default: state_r <= SPPL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // byte generator; every slot not named below is reserved zero
  always_comb begin
    gen_byte = 8'h0;
    gen_last = 1'b0;
    if (state_r == SPPL_HDR) begin
      gen_last = hdr_idx_r == `SPPL_HDR_LAST && count_r == 8'h0;
      case (hdr_idx_r)
        `SPPL_H_CODE:    gen_byte = `SPPL_PAGE_CODE;
        `SPPL_H_LEN_HI:  gen_byte = page_len[15:8];
        `SPPL_H_LEN_LO:  gen_byte = page_len[7:0];
        `SPPL_H_PORT_HI: gen_byte = port_id_r[15:8];
        `SPPL_H_PORT_LO: gen_byte = port_id_r[7:0];
        // criteria left zero: readers ignore it anyway
        `SPPL_H_CTRL:    gen_byte = {`SPPL_CTRL_ZERO, `SPPL_THR_CRIT, `SPPL_CTRL_FLAGS};
        `SPPL_H_PLEN:    gen_byte = param_len;
        `SPPL_H_PROTO:   gen_byte = {4'h0, `SPPL_PROTO_ID};
        `SPPL_H_COUNT:   gen_byte = count_r;
        default:         gen_byte = 8'h0;
      endcase
    end else if (state_r == SPPL_DESC) begin
      gen_last = dbyte_r == `SPPL_D_LAST && phy_r == count_r - 8'h1;
      // counters and addresses go out most significant byte first
      if (dbyte_r >= `SPPL_D_CNT) begin
        gen_byte = i_err_cnt[p*128 + 8*int'(4'hF - dbyte_r[3:0]) +: 8];
      end else if (dbyte_r >= `SPPL_D_SAS && dbyte_r < `SPPL_D_ATT) begin
        gen_byte = i_sas_addr[p*64 + 8*int'(3'h7 - dbyte_r[2:0]) +: 8];
      end else if (dbyte_r >= `SPPL_D_ATT && dbyte_r < `SPPL_D_ATT_PHY) begin
        gen_byte = i_att_addr[p*64 + 8*int'(3'h7 - dbyte_r[2:0]) +: 8];
      end else begin
        case (dbyte_r)
          `SPPL_D_PHY_ID:   gen_byte = i_phy_id[p*8 +: 8];
          `SPPL_D_DEV_TYPE: gen_byte = {1'b0, i_att_dev_type[p*3 +: 3], 4'h0};
          `SPPL_D_RATE:     gen_byte = {4'h0, i_link_rate[p*4 +: 4]};
          `SPPL_D_INIT:     gen_byte = {4'h0, i_att_init[p*3 +: 3], 1'b0};
          `SPPL_D_TGT:      gen_byte = {4'h0, i_att_tgt[p*3 +: 3], 1'b0};
          `SPPL_D_ATT_PHY:  gen_byte = i_att_phy_id[p*8 +: 8];
          default:          gen_byte = 8'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output stage: holds a byte until the reader takes it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_byte_data  <= 8'h0;
      o_byte_valid <= 1'b0;
      o_byte_last  <= 1'b0;
      out_pos_r    <= 16'h0;
      out_dbyte_r  <= 6'h0;
      out_desc_r   <= 1'b0;
    end else if (load) begin
      o_byte_data  <= gen_byte;
      o_byte_valid <= 1'b1;
      o_byte_last  <= gen_last;
      out_pos_r    <= gen_pos_r;
      // slot bookkeeping rides with the byte, for the checks only
      out_dbyte_r  <= dbyte_r;
      out_desc_r   <= state_r == SPPL_DESC;
    end else if (i_byte_ready) begin
      o_byte_valid <= 1'b0;
      o_byte_last  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // positions count from the page code byte; param_tot is the parameter list length
  logic [15:0] param_tot;
  assign param_tot = `SPPL_PARAM_HDR + 16'(`SPPL_DESC_BYTES * count_r);

  a_page_code: assert property (o_byte_valid && out_pos_r == 16'h0 |-> o_byte_data == 8'h18)
    else $error("page code byte wrong");
  a_page_len: assert property (o_byte_valid && out_pos_r == 16'h3 |-> o_byte_data == param_tot[7:0])
    else $error("page length low byte wrong");
  a_port_code: assert property (o_byte_valid && out_pos_r == 16'h4 |-> o_byte_data == port_id_r[15:8])
    else $error("parameter code high byte wrong");
  a_ctrl_zero: assert property (o_byte_valid && out_pos_r == 16'h6 |-> o_byte_data[7:4] == 4'h0)
    else $error("control disable bits not zero");
  a_ctrl_flags: assert property (o_byte_valid && out_pos_r == 16'h6 |-> o_byte_data[1:0] == 2'h3)
    else $error("binary and list flags not set");
  a_param_len: assert property (o_byte_valid && out_pos_r == 16'h7 |-> o_byte_data == 8'(param_tot - 16'h3))
    else $error("parameter length wrong");
  a_proto_id: assert property (o_byte_valid && out_pos_r == 16'h8 |-> o_byte_data == 8'h06)
    else $error("protocol identifier wrong");
  a_phy_count: assert property (o_byte_valid && out_pos_r == 16'hB |-> o_byte_data == count_r)
    else $error("phy count wrong");
  a_frame_len: assert property (o_byte_valid && o_byte_last |-> out_pos_r == param_tot + 16'h3)
    else $error("page ends at wrong byte");
  a_desc_rsvd: assert property (o_byte_valid && out_pos_r == 16'hC |-> o_byte_data == 8'h0)
    else $error("descriptor byte zero not reserved");
  a_hold_byte: assert property (o_byte_valid && !i_byte_ready |=> $stable(o_byte_data) && o_byte_valid)
    else $error("byte dropped under stall");
  a_wb_ack: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("wishbone ack not one cycle");

  // remaining header slots
  a_len_high: assert property (o_byte_valid && out_pos_r == 16'h2 |-> o_byte_data == param_tot[15:8])
    else $error("page length high byte wrong");
  a_port_low: assert property (o_byte_valid && out_pos_r == 16'h5 |-> o_byte_data == port_id_r[7:0])
    else $error("parameter code low byte wrong");
  a_crit_zero: assert property (o_byte_valid && out_pos_r == 16'h6 |-> o_byte_data[3:2] == 2'h0)
    else $error("threshold criteria not emitted as zero");
  a_hdr_rsvd: assert property (o_byte_valid && out_pos_r inside {16'h1, 16'h9, 16'hA}
                               |-> o_byte_data == 8'h0)
    else $error("header reserved byte not zero");

  // descriptor reserved bits, judged by the slot each byte came from
  a_type_rsvd: assert property (o_byte_valid && out_desc_r && out_dbyte_r == `SPPL_D_DEV_TYPE
                                |-> o_byte_data[7] == 1'b0 && o_byte_data[3:0] == 4'h0)
    else $error("device type byte reserved bits set");
  a_rate_rsvd: assert property (o_byte_valid && out_desc_r && out_dbyte_r == `SPPL_D_RATE
                                |-> o_byte_data[7:4] == 4'h0)
    else $error("link rate byte reserved bits set");
  a_flag_rsvd: assert property (o_byte_valid && out_desc_r &&
                                out_dbyte_r inside {`SPPL_D_INIT, `SPPL_D_TGT}
                                |-> o_byte_data[7:4] == 4'h0 && o_byte_data[0] == 1'b0)
    else $error("port flag byte reserved bits set");
  a_gap_rsvd: assert property (o_byte_valid && out_desc_r &&
                               (out_dbyte_r inside {6'h00, 6'h02, 6'h03} ||
                                (out_dbyte_r > `SPPL_D_ATT_PHY && out_dbyte_r < `SPPL_D_CNT))
                               |-> o_byte_data == 8'h0)
    else $error("descriptor reserved byte not zero");

  // stream order and refusals
  a_first_byte: assert property (start_req && !busy && count_cfg_r <= 8'(MAX_PHYS)
                                 |=> ##1 o_byte_valid && out_pos_r == 16'h0)
    else $error("first byte not two cycles after start");
  a_pos_step: assert property (o_byte_valid && i_byte_ready && !o_byte_last
                               |=> o_byte_valid && out_pos_r == $past(out_pos_r) + 16'h1)
    else $error("byte position skipped or repeated");
  a_last_idle: assert property (o_byte_valid && o_byte_last |-> state_r == SPPL_IDLE)
    else $error("generator still running after last byte");
  a_last_drain: assert property (o_byte_valid && o_byte_last && i_byte_ready |=> !o_byte_valid)
    else $error("byte after the last one");
  a_idle_quiet: assert property (state_r == SPPL_IDLE && !o_byte_valid |=> !o_byte_valid)
    else $error("byte outside a page");
  a_valid_last: assert property (!o_byte_valid |-> !o_byte_last)
    else $error("last flag without a byte");
  a_count_refuse: assert property (start_req && !busy && count_cfg_r > 8'(MAX_PHYS)
                                   |=> err_r && state_r == SPPL_IDLE)
    else $error("oversized phy count not refused");
  a_start_ignored: assert property (start_req && busy |=> $stable(count_r) && $stable(err_r))
    else $error("start accepted while busy");

  c_empty_page: cover property (o_byte_last && out_pos_r == 16'hB);
  c_full_page: cover property (o_byte_last && count_r == 8'(MAX_PHYS));
  c_stall: cover property (o_byte_valid && !i_byte_ready ##1 i_byte_ready);
  c_refused: cover property (start_req && count_cfg_r > 8'(MAX_PHYS));
  c_back_to_back: cover property (o_byte_valid && i_byte_ready ##1 o_byte_valid && i_byte_ready);

endmodule : sppl_builder
`default_nettype wire

// File: verilog/sppl_defines.svh
`ifndef SPPL_DEFINES_SVH
`define SPPL_DEFINES_SVH
// register byte offsets
`define SPPL_ADR_CTRL    4'h0
`define SPPL_ADR_PORT    4'h4
`define SPPL_ADR_COUNT   4'h8
`define SPPL_ADR_STATUS  4'hC
// control and status register bits
`define SPPL_CTRL_START  0
`define SPPL_STAT_BUSY   0
`define SPPL_STAT_ERR    1
// page and parameter constants
`define SPPL_PAGE_CODE   8'h18
`define SPPL_PROTO_ID    4'h6
`define SPPL_CTRL_ZERO   4'h0
`define SPPL_THR_CRIT    2'h0
`define SPPL_CTRL_FLAGS  2'h3
`define SPPL_PARAM_HDR   16'h0008
`define SPPL_DESC_BYTES  16'h0030
`define SPPL_PLEN_ADJ    16'h0003
`define SPPL_HDR_LAST    4'hB
`define SPPL_DESC_FIRST  16'h000C
// page header byte slots
`define SPPL_H_CODE      4'h0
`define SPPL_H_LEN_HI    4'h2
`define SPPL_H_LEN_LO    4'h3
`define SPPL_H_PORT_HI   4'h4
`define SPPL_H_PORT_LO   4'h5
`define SPPL_H_CTRL      4'h6
`define SPPL_H_PLEN      4'h7
`define SPPL_H_PROTO     4'h8
`define SPPL_H_COUNT     4'hB
// descriptor byte slots
`define SPPL_D_PHY_ID    6'h01
`define SPPL_D_DEV_TYPE  6'h04
`define SPPL_D_RATE      6'h05
`define SPPL_D_INIT      6'h06
`define SPPL_D_TGT       6'h07
`define SPPL_D_SAS       6'h08
`define SPPL_D_ATT       6'h10
`define SPPL_D_ATT_PHY   6'h18
`define SPPL_D_CNT       6'h20
`define SPPL_D_LAST      6'h2F
`endif

// File: verilog/sppl_pkg.sv
package sppl_pkg;
  // generator states, gray along idle -> header -> descriptors
  typedef enum logic [1:0] {
    SPPL_IDLE = 2'h0,
    SPPL_HDR  = 2'h1,
    SPPL_DESC = 2'h3
  } sppl_state_e;
endpackage : sppl_pkg

// File: verification/sppl_reader.sv
`timescale 1ns/10ps
`default_nettype none
// reader of the page byte stream, prompt or with random stalls
module sppl_reader (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  // bench control
  input  wire logic       i_clear,
  input  wire logic       i_slow,
  // page byte stream
  input  wire logic [7:0] i_byte_data,
  input  wire logic       i_byte_valid,
  input  wire logic       i_byte_last,
  output logic            o_byte_ready
);
  logic [7:0] mem [0:255];
  int         n_got;
  int         last_at;
  logic       got_last;
  ////////////////////////////////////////
  // keep every taken byte raw; threshold criteria is stored, never acted on
  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_clear) begin
      o_byte_ready <= 1'b0;
      n_got        <= 0;
      last_at      <= -1;
      got_last     <= 1'b0;
    end else begin
      o_byte_ready <= i_slow ? 1'($urandom % 2) : 1'b1;  // stalls stress the hold rule
      if (i_byte_valid && o_byte_ready && n_got < 256) begin
        mem[n_got] <= i_byte_data;
        n_got      <= n_got + 1;
        if (i_byte_last) begin
          got_last <= 1'b1;
          last_at  <= n_got;
        end
      end
    end
  end
endmodule : sppl_reader
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int P = 4;
  logic             clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slow = 0, clr = 0, ack, bval, blast, brdy;
  logic [3:0]       adr = 0, sel = 0;
  logic [31:0]      wdat = 0, wb_q, q;
  logic [7:0]       bdat;
  logic [P*8-1:0]   phy_id = 0, att_phy = 0;
  logic [P*3-1:0]   dtype = 0, ainit = 0, atgt = 0;
  logic [P*4-1:0]   rate = 0;
  logic [P*64-1:0]  sas = 0, att = 0;
  logic [P*128-1:0] err = 0;
  int               n_mismatch = 0, n_tests = 0, cyc_n = 0;
  ////////////////////////////////////////
  sppl_builder #(.MAX_PHYS(P)) uut (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wb_q), .o_wb_ack(ack),
    .i_phy_id(phy_id), .i_att_dev_type(dtype), .i_link_rate(rate), .i_att_init(ainit), .i_att_tgt(atgt),
    .i_sas_addr(sas), .i_att_addr(att), .i_att_phy_id(att_phy), .i_err_cnt(err),
    .i_byte_ready(brdy), .o_byte_data(bdat), .o_byte_valid(bval), .o_byte_last(blast));
  sppl_reader rd (.i_core_clk(clk), .i_reset(rst), .i_clear(clr), .i_slow(slow), .i_byte_data(bdat),
    .i_byte_valid(bval), .i_byte_last(blast), .o_byte_ready(brdy));
  ////////////////////////////////////////
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // classic cycle: hold until ack is seen at a rising edge, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = wb_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("wb ack", 32'h1, {31'h0, k < 50});
  endtask : wb
  function automatic logic [7:0] exp_byte(int i, logic [15:0] port, int n);
    logic [15:0] len;
    int          d, p;
    len = 16'(8 + 48 * n);
    if (i < 12) begin
      case (i)
        0: return 8'h18;
        2: return len[15:8];
        3: return len[7:0];
        4: return port[15:8];
        5: return port[7:0];
        6: return 8'h03;
        7: return 8'(len - 16'h3);
        8: return 8'h06;
        11: return 8'(n);
        default: return 8'h00;
      endcase
    end
    d = (i - 12) % 48;
    p = (i - 12) / 48;
    if (d == 1) return phy_id[p*8+:8];
    if (d == 4) return {1'b0, dtype[p*3+:3], 4'h0};
    if (d == 5) return {4'h0, rate[p*4+:4]};
    if (d == 6) return {4'h0, ainit[p*3+:3], 1'b0};
    if (d == 7) return {4'h0, atgt[p*3+:3], 1'b0};
    if (d >= 8 && d <= 15) return sas[p*64+(15-d)*8+:8];
    if (d >= 16 && d <= 23) return att[p*64+(23-d)*8+:8];
    if (d == 24) return att_phy[p*8+:8];
    if (d >= 32) return err[p*128+(47-d)*8+:8];
    return 8'h00;
  endfunction : exp_byte
  // one page: program, start, poke a second start while busy when n > 0, check every byte
  task automatic run(input logic [15:0] port, input int n, input logic s, input logic ones);
    int k, tot;
    logic [1151:0] rv;
    tot = 12 + 48 * n;
    for (int j = 0; j < 36; j++) rv[j*32 +: 32] = $urandom;
    @(posedge clk);
    if (ones) {phy_id, att_phy, dtype, ainit, atgt, rate, sas, att, err} <= '1;
    else {phy_id, att_phy, dtype, ainit, atgt, rate, sas, att, err} <= rv[1139:0];
    slow <= s;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wb(1'b1, 4'h4, {16'h0, port}, q);
    wb(1'b1, 4'h8, 32'(n), q);
    wb(1'b0, 4'h4, 0, q);
    chk("port reg", {16'h0, port}, q);
    wb(1'b1, 4'h0, 32'h1, q);
    if (n > 0) begin
      wb(1'b0, 4'hC, 0, q);
      chk("busy", 32'h1, q & 32'h1);
      wb(1'b1, 4'h0, 32'h1, q);
    end
    k = 0;
    while (rd.got_last !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    repeat (3) @(negedge clk);
    chk("bytes taken", 32'(tot), 32'(rd.n_got));
    chk("last index", 32'(tot - 1), 32'(rd.last_at));
    chk("valid after page", 32'h0, {31'h0, bval});
    for (int i = 0; i < tot; i++) begin
      if (i == 6) chk("ctrl byte", {24'h0, exp_byte(i, port, n)}, {24'h0, rd.mem[i] & 8'hF3});
      else chk($sformatf("byte %0d", i), {24'h0, exp_byte(i, port, n)}, {24'h0, rd.mem[i]});
    end
    wb(1'b0, 4'hC, 0, q);
    chk("status idle", 32'h0, q);
  endtask : run
  ////////////////////////////////////////
  // main sequence
  initial begin
    q = $urandom(32'h980a);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 4'h2, 0, q);
    chk("unmapped read", 32'h0, q);
    run(16'h0000, 0, 1'b0, 1'b0);
    run(16'hFFFF, P, 1'b1, 1'b1);
    for (int t = 0; t < 3; t++) run(16'($urandom), 1 + $urandom % P, 1'($urandom), 1'b0);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wb(1'b1, 4'h8, 32'(P + 1), q);
    wb(1'b1, 4'h0, 32'h1, q);
    repeat (30) @(negedge clk);
    chk("refused bytes", 32'h0, 32'(rd.n_got));
    wb(1'b0, 4'hC, 0, q);
    chk("count error", 32'h2, q);
    // reset in the middle of a page
    wb(1'b1, 4'h8, 32'(P), q);
    wb(1'b1, 4'h0, 32'h1, q);
    repeat (5) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("valid after reset", 32'h0, {31'h0, bval});
    wb(1'b0, 4'hC, 0, q);
    chk("status after reset", 32'h0, q);
    wb(1'b0, 4'h8, 0, q);
    chk("count after reset", 32'h0, q);
    run(16'h0001, 1, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
